// >>> lcdc_defs.svh
// constants for the lcd command decoder
`ifndef LCDC_DEFS_SVH
`define LCDC_DEFS_SVH
`define LCDC_ONOFF_OP 7'h1f
`define LCDC_START_OP 2'h3
`define LCDC_PAGE_OP 5'h17
`define LCDC_COL_OP 2'h1
`define LCDC_STATUS_RST 8'h20
`define LCDC_ST_BUSY 7
`define LCDC_ST_OFF 5
`define LCDC_ST_RESET 4
`define LCDC_ROWS 64
`define LCDC_BUSY_NS 100
`define LCDC_CLK_NS 100
`define LCDC_BUSY_CYC ((`LCDC_BUSY_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)
`endif

// >>> lcdc_pkg.sv
// types for the lcd command decoder
package lcdc_pkg;
  typedef struct packed {
    logic data_sel;
    logic read_sel;
    logic [7:0] bus;
  } lcdc_xfer_t;
  typedef enum logic [1:0] {
    LCDC_IDLE,
    LCDC_BUSY
  } lcdc_state_t;
endpackage : lcdc_pkg

// >>> lcdc_top.sv
// lcd command decoder: host bus, control registers, row scan
//
// Notes on behaviour
// - on/off register, cleared by reset
// - six-bit start line register, reset zero
// - three-bit page pointer, undefined at reset
// - six-bit column pointer, undefined at reset
// - status reads 0x20 after reset
// - instruction write uses select low, write low
// - 0x3e/0x3f loads bit 0 into on/off
// - 0x3e clears on/off, panel off
// - top bits 11 load start line low six
// - start line accepted for c0 through ff
// - select high data, low instruction
// - status bit 7 marks busy; host waits
`include "lcdc_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module lcdc_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable_strobe,
  input wire logic data_sel,
  input wire logic read_sel,
  input wire logic [7:0] bus_in,
  input wire logic row_advance,
  output logic [7:0] bus_out,
  output logic bus_oe,
  output logic panel_on,
  output logic [5:0] first_common_row,
  output logic [5:0] scan_row,
  output logic [2:0] page_out,
  output logic [5:0] column_out,
  output logic busy,
  output logic data_wr,
  output logic [7:0] data_wr_byte
);

  ////////////////////////////////////////////////////////////////////////
  // strobe edge detect
  logic strobe_q;
  logic strobe_d;
  logic fall;
  lcdc_pkg::lcdc_xfer_t xfer;

  always_comb
  begin
    strobe_d = enable_strobe;
    fall = strobe_q & ~enable_strobe;
    xfer.data_sel = data_sel;
    xfer.read_sel = read_sel;
    xfer.bus = bus_in;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      strobe_q <= 1'b0;
    else
      strobe_q <= strobe_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode and registers
  logic display_enable_q, display_enable_d;
  logic [5:0] scan_first_row_q, scan_first_row_d;
  logic [2:0] page_pointer_q, page_pointer_d;
  logic [5:0] column_pointer_q, column_pointer_d;
  logic [1:0] busy_cnt_q, busy_cnt_d;
  logic in_reset_q, in_reset_d;
  lcdc_pkg::lcdc_state_t state_q, state_d;
  logic wr_q, wr_d;
  logic [7:0] wr_byte_q, wr_byte_d;
  logic instr_wr;
  logic [3:0] kind;

  function automatic logic [5:0] wrap_row(input logic [5:0] a,
                                          input logic [5:0] b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[5:0];
  endfunction : wrap_row

  // command kind flags: {on/off, start line, page, column}
  function automatic logic [3:0] classify(input logic [7:0] b);
    logic [3:0] k;
    k = 4'h0;
    if (b[7:1] == `LCDC_ONOFF_OP)
      k[3] = 1'b1;
    else if (b[7:6] == `LCDC_START_OP)
      k[2] = 1'b1;
    else if (b[7:3] == `LCDC_PAGE_OP)
      k[1] = 1'b1;
    else if (b[7:6] == `LCDC_COL_OP)
      k[0] = 1'b1;
    return k;
  endfunction : classify

  always_comb
  begin
    display_enable_d = display_enable_q;
    scan_first_row_d = scan_first_row_q;
    page_pointer_d = page_pointer_q;
    column_pointer_d = column_pointer_q;
    busy_cnt_d = busy_cnt_q;
    state_d = state_q;
    in_reset_d = 1'b0;
    wr_d = 1'b0;
    wr_byte_d = wr_byte_q;
    instr_wr = fall & ~xfer.data_sel & ~xfer.read_sel;
    kind = classify(xfer.bus);
    case (state_q)
      lcdc_pkg::LCDC_IDLE:
      begin
        if (fall & ~xfer.read_sel)
        begin
          state_d = lcdc_pkg::LCDC_BUSY;
          busy_cnt_d = 2'(`LCDC_BUSY_CYC);
        end
        if (instr_wr)
        begin
          if (kind[3])
            display_enable_d = xfer.bus[0];
          if (kind[2])
            scan_first_row_d = xfer.bus[5:0];
          if (kind[1])
            page_pointer_d = xfer.bus[2:0];
          if (kind[0])
            column_pointer_d = xfer.bus[5:0];
        end
        else if (fall & xfer.data_sel & ~xfer.read_sel)
        begin
          wr_d = 1'b1;
          wr_byte_d = xfer.bus;
          column_pointer_d = column_pointer_q + 6'h01;
        end
      end
      lcdc_pkg::LCDC_BUSY:
      begin
        if (busy_cnt_q == 2'h0)
          state_d = lcdc_pkg::LCDC_IDLE;
        else
          busy_cnt_d = busy_cnt_q - 2'h1;
      end
      default: state_d = lcdc_pkg::LCDC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      display_enable_q <= 1'b0;
      scan_first_row_q <= 6'h00;
      busy_cnt_q <= 2'h0;
      state_q <= lcdc_pkg::LCDC_IDLE;
      in_reset_q <= 1'b1;
      wr_q <= 1'b0;
      wr_byte_q <= 8'h00;
    end
    else
    begin
      display_enable_q <= display_enable_d;
      scan_first_row_q <= scan_first_row_d;
      busy_cnt_q <= busy_cnt_d;
      state_q <= state_d;
      in_reset_q <= in_reset_d;
      wr_q <= wr_d;
      wr_byte_q <= wr_byte_d;
    end
  end

  // pointers keep no reset value
  always_ff @(posedge clk)
  begin
    page_pointer_q <= page_pointer_d;
    column_pointer_q <= column_pointer_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // busy flag register
  logic busy_q, busy_d;

  always_comb
  begin
    busy_d = (state_d == lcdc_pkg::LCDC_BUSY);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      busy_q <= 1'b0;
    else
      busy_q <= busy_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // status read and row scan
  logic [7:0] status;
  logic [5:0] scan_row_d;
  logic [7:0] bus_out_q, bus_out_d;
  logic bus_oe_q, bus_oe_d;
  logic [5:0] row_ctr_q, row_ctr_d;

  always_comb
  begin
    status = 8'h00;
    status[`LCDC_ST_BUSY] = (state_q == lcdc_pkg::LCDC_BUSY);
    status[`LCDC_ST_OFF] = ~display_enable_q;
    status[`LCDC_ST_RESET] = in_reset_q;
    bus_oe_d = enable_strobe & xfer.read_sel & ~xfer.data_sel;
    bus_out_d = bus_oe_d ? status : 8'h00;
    row_ctr_d = row_advance ? row_ctr_q + 6'h01 : row_ctr_q;
    scan_row_d = wrap_row(scan_first_row_d, row_ctr_d);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_out_q <= 8'h00;
      bus_oe_q <= 1'b0;
      row_ctr_q <= 6'h00;
      scan_row <= 6'h00;
    end
    else
    begin
      bus_out_q <= bus_out_d;
      bus_oe_q <= bus_oe_d;
      row_ctr_q <= row_ctr_d;
      scan_row <= scan_row_d;
    end
  end

  always_comb
  begin
    bus_out = bus_out_q;
    bus_oe = bus_oe_q;
    panel_on = display_enable_q;
    first_common_row = scan_first_row_q;
    page_out = page_pointer_q;
    column_out = column_pointer_q;
    busy = busy_q;
    data_wr = wr_q;
    data_wr_byte = wr_byte_q;
  end

endmodule : lcdc_top
`default_nettype wire

// >>> lcdc_checker.sv
// lcdc assertions
`timescale 1ns/1ns
`default_nettype none
module lcdc_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable_strobe,
  input wire logic data_sel,
  input wire logic read_sel,
  input wire logic [7:0] bus_in,
  input wire logic [7:0] bus_out,
  input wire logic bus_oe,
  input wire logic panel_on,
  input wire logic [5:0] first_common_row,
  input wire logic busy,
  input wire logic data_wr
);
  logic stb_q;
  logic take;
  logic [7:0] cmd_q;
  assign take = stb_q && !enable_strobe && !busy;
  always_ff @(posedge clk)
  begin
    stb_q <= enable_strobe;
    if (take) cmd_q <= bus_in;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_ins; take && !data_sel && !read_sel; endsequence
  sequence s_dat; take && data_sel && !read_sel; endsequence
  a_rst_off: assert property ($fell(sys_rst) |-> !panel_on)
    else $error("panel on after reset");
  a_rst_row: assert property ($fell(sys_rst) |-> !first_common_row)
    else $error("start line not zero");
  a_on_cmd: assert property (s_ins ##0 bus_in == 8'h3f |-> ##[1:2] panel_on)
    else $error("panel not on");
  a_off_cmd:
    assert property (s_ins ##0 bus_in == 8'h3e |-> ##[1:2] !panel_on)
    else $error("panel not off");
  a_start_load:
    assert property (s_ins ##0 bus_in[7:6] == 2'h3 |->
      ##[1:2] first_common_row == cmd_q[5:0]) else $error("start line");
  a_busy_rise: assert property (s_ins |-> ##[1:2] busy)
    else $error("no busy");
  a_busy_end: assert property ($rose(busy) |-> ##[1:3] !busy)
    else $error("busy stuck");
  a_data_pulse: assert property (s_dat |-> ##[1:2] data_wr)
    else $error("no data write");
  a_data_keep:
    assert property (s_dat |=> $stable(panel_on) ##1 $stable(panel_on))
    else $error("data changed panel");
  a_status_bits:
    assert property (bus_oe |-> bus_out[5] != panel_on && !bus_out[3:0])
    else $error("status bits");
endmodule : lcdc_checker
bind lcdc_top lcdc_checker u_lcdc_checker (.clk, .sys_rst, .enable_strobe,
  .data_sel, .read_sel, .bus_in, .bus_out, .bus_oe, .panel_on,
  .first_common_row, .busy, .data_wr);
`default_nettype wire

// >>> lcdc_host.sv
// host bus model
`timescale 1ns/1ns
`default_nettype none
module lcdc_host (
  input wire logic clk,
  input wire logic busy,
  input wire logic bus_oe,
  input wire logic [7:0] bus_out,
  output logic enable_strobe = 1'b0,
  output logic data_sel = 1'b0,
  output logic read_sel = 1'b0,
  output logic [7:0] bus_in = 8'h00
);
  logic [7:0] rdata;
  task xfer(input logic sel, input logic rd, input logic [7:0] b);
    int n;
    @(posedge clk);
    enable_strobe <= 1'b1;
    data_sel <= sel;
    read_sel <= rd;
    bus_in <= b;
    @(posedge clk);
    @(negedge clk);
    rdata = bus_oe ? bus_out : 8'hxx;
    @(posedge clk);
    enable_strobe <= 1'b0;
    @(posedge clk);
    bus_in <= ~b;
    n = 0;
    repeat (2) @(negedge clk);
    while (busy && n < 8)
    begin
      @(negedge clk);
      n++;
    end
  endtask : xfer
endmodule : lcdc_host
`default_nettype wire

// >>> test_lcdc_top.sv
// lcdc testbench
`timescale 1ns/1ns
`default_nettype none
module test_lcdc_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic row_advance = 1'b0;
  logic enable_strobe, data_sel, read_sel, bus_oe, panel_on, busy, data_wr;
  logic [7:0] bus_in, bus_out, data_wr_byte;
  logic [5:0] first_common_row, scan_row, column_out;
  logic [2:0] page_out;
  int miscompares = 0;
  int n_compared = 0;
  always #50 clk = ~clk;
  lcdc_top u_lcdc_top (.clk, .sys_rst, .enable_strobe, .data_sel,
    .read_sel, .bus_in, .row_advance, .bus_out, .bus_oe, .panel_on,
    .first_common_row, .scan_row, .page_out, .column_out, .busy,
    .data_wr, .data_wr_byte);
  lcdc_host u_lcdc_host (.clk, .busy, .bus_oe, .bus_out, .enable_strobe,
    .data_sel, .read_sel, .bus_in);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task wr(input logic [7:0] b);
    u_lcdc_host.xfer(1'b0, 1'b0, b);
  endtask : wr
  task t_status(input logic [7:0] exp);
    u_lcdc_host.xfer(1'b0, 1'b1, 8'h00);
    chk(u_lcdc_host.rdata, exp);
  endtask : t_status
  task t_onoff;
    chk({7'h0, panel_on}, 8'h00);
    chk({2'h0, first_common_row}, 8'h00);
    wr(8'h3f);
    chk({7'h0, panel_on}, 8'h01);
    t_status(8'h00);
    wr(8'h3e);
    chk({7'h0, panel_on}, 8'h00);
    t_status(8'h20);
  endtask : t_onoff
  task t_start;
    logic [7:0] c;
    for (int i = 0; i < 3; i++)
    begin
      c = (i == 0) ? 8'hc0 : (i == 1) ? 8'hff : 8'he5;
      wr(c);
      chk({2'h0, first_common_row}, {2'h0, c[5:0]});
    end
  endtask : t_start
  task t_ptr;
    wr(8'hbd);
    wr(8'h69);
    chk({5'h0, page_out}, 8'h05);
    chk({2'h0, column_out}, 8'h29);
    u_lcdc_host.xfer(1'b1, 1'b0, 8'h3f);
    chk({7'h0, panel_on}, 8'h00);
    chk(data_wr_byte, 8'h3f);
    chk({2'h0, column_out}, 8'h2a);
  endtask : t_ptr
  task t_scan;
    @(posedge clk);
    row_advance <= 1'b1;
    repeat (3) @(posedge clk);
    row_advance <= 1'b0;
    @(negedge clk);
    chk({2'h0, scan_row}, 8'h28);
    wr(8'hff);
    chk({2'h0, scan_row}, 8'h02);
    wr(8'h3f);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk({7'h0, panel_on}, 8'h00);
    chk({2'h0, first_common_row}, 8'h00);
    chk({2'h0, scan_row}, 8'h00);
    t_status(8'h20);
  endtask : t_scan
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_status(8'h20);
    t_onoff;
    t_start;
    t_ptr;
    t_scan;
    print_verdict;
  end
  initial
  begin
    #100000;
    miscompares++;
    print_verdict;
  end
endmodule : test_lcdc_top
`default_nettype wire
